//--- rtl/mptd_pkg.sv
// Package: register map, field layout and timing constants of the PWM time base
package mptd_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] ADDR_TB_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TB_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_TB_PERIOD  = 8'h08;
  localparam logic [7:0] ADDR_DUTY_BASE  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS     = 8'h1C;
  localparam int         NUM_GEN         = 4;
  localparam int         CNT_W           = 15;
  localparam int         DUTY_W          = 16;
  // Control register fields
  localparam int         CTL_EN_BIT      = 15;
  localparam int         CTL_IUE_BIT     = 14;
  localparam int         CTL_OPS_LSB     = 4;
  localparam int         CTL_CKPS_LSB    = 2;
  localparam int         CTL_MOD_LSB     = 0;
  localparam int         CNT_DIR_BIT     = 15;
  localparam logic [15:0] CTL_RESET      = 16'h0000;
  localparam logic [14:0] PER_RESET      = 15'h0000;
  localparam logic [15:0] DUTY_RESET     = 16'h0000;
  // Prescale divide counts minus one
  localparam logic [5:0] PRE_DIV1        = 6'h00;
  localparam logic [5:0] PRE_DIV4        = 6'h03;
  localparam logic [5:0] PRE_DIV16       = 6'h0F;
  localparam logic [5:0] PRE_DIV64       = 6'h3F;
  // Time-base modes
  localparam logic [1:0] MODE_FREE       = 2'h0;
  localparam logic [1:0] MODE_SINGLE     = 2'h1;
  localparam logic [1:0] MODE_UPDOWN     = 2'h2;
  localparam logic [1:0] MODE_DOUBLE     = 2'h3;
  typedef enum logic [1:0] {MPTD_IDLE, MPTD_RUN} mptd_state_type;
endpackage

//--- rtl/mptd_duty_compare.sv
// One duty-cycle comparison unit with double-buffered compare value
`timescale 1ns/1ps
`default_nettype none
module mptd_duty_compare
  import mptd_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Time base
  input  wire logic [CNT_W-1:0]  count_i,
  input  wire logic [CNT_W-1:0]  period_i,
  input  wire logic              counting_down_i,
  input  wire logic              center_i,
  input  wire logic              tick_i,
  input  wire logic              half_tick_i,
  input  wire logic              period_start_i,
  // Duty value
  input  wire logic [DUTY_W-1:0] buffer_i,
  input  wire logic              load_i,
  output logic                   active_o
);
  logic [DUTY_W-1:0] active_duty;
  logic [DUTY_W-1:0] next_active_duty;
  logic              out_q;
  logic              next_out_q;
  logic              hit;
  logic              hit_late;
  logic              ahead;

  // Upper bits match the count; bit 0 moves the edge half a tick later
  assign hit      = (active_duty[DUTY_W-1:1] == count_i);
  assign hit_late = active_duty[0] ? half_tick_i : tick_i;
  assign ahead    = (active_duty[DUTY_W-1:1] > count_i);

  always_comb begin
    next_active_duty = load_i ? buffer_i : active_duty;
    next_out_q       = out_q;
    if (!center_i) begin
      // Level compare at every step, so an immediate write shortens or stretches the pulse
      if (period_start_i) begin
        next_out_q = (active_duty != DUTY_RESET);
      end else if (tick_i) begin
        next_out_q = ahead || (hit && active_duty[0]);
      end
      if (hit && active_duty[0] && half_tick_i) begin
        next_out_q = 1'b0;
      end
    end else begin
      if (active_duty == DUTY_RESET) begin
        next_out_q = 1'b0;
      end else if (active_duty[DUTY_W-1:1] >= period_i) begin
        next_out_q = 1'b1;
      end else if (hit && hit_late) begin
        next_out_q = counting_down_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      active_duty <= DUTY_RESET;
      out_q       <= 1'b0;
    end else begin
      active_duty <= next_active_duty;
      out_q       <= next_out_q;
    end
  end

  assign active_o = out_q;
endmodule
`default_nettype wire

//--- rtl/mptd_timebase.sv
// PWM time base, period buffer, APB registers and four duty comparators
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Function
// - 15-bit counter with prescaler and postscaler
// - Count bit 15 reads direction, read-only
// - Enable runs counter; disable keeps count
// - Period match resets or reverses next tick
// - Zero period halts counter, no events
// - Free-run: clear after match, postscaled event
// - Single-shot: event, clear, self-disable
// - Up/down: postscaled event at zero turnaround
// - Double update: events at zero and match
// - Prescale 1, 4, 16 or 64
// - Count or control write clears prescaler
// - Postscaler divides events 1 to 16
// - Count or control write clears postscaler
// - Period buffer loads at period boundary
// - Period buffer loads while disabled
// - Up/down period spans twice the count
// - Edge-aligned: active at zero, off at duty
// - Edge duty zero off, above period on
// - Center: on when down-match, off up-match
// - Center duty zero off, equal period on
// - Four 16-bit duty registers, half-step LSB
// - Duty buffers load at update points
// - Immediate update applies duty write now
module mptd_timebase
  import mptd_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // APB slave
  input  wire logic         psel_i,
  input  wire logic         penable_i,
  input  wire logic         pwrite_i,
  input  wire logic [7:0]   paddr_i,
  input  wire logic [31:0]  pwdata_i,
  output logic              pready_o,
  output logic [31:0]       prdata_o,
  output logic              pslverr_o,
  // Time base events and outputs
  output logic              tb_event_o,
  output logic [NUM_GEN-1:0] pwm_active_o
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0]          control;
  logic [15:0]          next_control;
  logic [CNT_W-1:0]     count;
  logic [CNT_W-1:0]     next_count;
  logic                 dir_down;
  logic                 next_dir_down;
  logic [CNT_W-1:0]     period_buf;
  logic [CNT_W-1:0]     next_period_buf;
  logic [CNT_W-1:0]     period;
  logic [CNT_W-1:0]     next_period;
  logic [5:0]           pre_cnt;
  logic [5:0]           next_pre_cnt;
  logic [3:0]           post_cnt;
  logic [3:0]           next_post_cnt;
  logic [DUTY_W-1:0]    duty_buf [NUM_GEN];
  logic [DUTY_W-1:0]    next_duty_buf [NUM_GEN];
  logic                 event_q;
  logic                 next_event_q;
  logic                 ready_q;
  logic                 next_ready_q;
  logic [31:0]          rdata_q;
  logic [31:0]          next_rdata_q;
  logic                 err_q;
  logic                 next_err_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic       access;
  logic       wr;
  logic       wr_ctl;
  logic       wr_cnt;
  logic       wr_per;
  logic [NUM_GEN-1:0] wr_duty;
  logic       tb_en;
  logic       immediate_update_enable;
  logic [1:0] mode;
  logic [3:0] ops;
  logic [1:0] ckps;
  logic       center;
  logic [5:0] pre_max;
  logic       tick;
  logic       half_tick;
  logic       step_start;
  logic [5:0] half_cnt;
  logic       match;
  logic       at_zero;
  logic       duty_load;
  logic       period_start;
  logic       raw_event;
  logic       post_used;

  // Word address decode, shared by write and read paths
  function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] base);
    hit_addr = (a == base);
  endfunction

  // Access phase takes one wait state: pready is registered high the cycle after psel and penable
  assign access = psel_i && penable_i && !ready_q;
  assign wr     = access && pwrite_i;
  assign wr_ctl = wr && hit_addr(paddr_i, ADDR_TB_CONTROL);
  assign wr_cnt = wr && hit_addr(paddr_i, ADDR_TB_COUNT);
  assign wr_per = wr && hit_addr(paddr_i, ADDR_TB_PERIOD);

  genvar g;
  generate
    for (g = 0; g < NUM_GEN; g++) begin : g_dec
      assign wr_duty[g] = wr && hit_addr(paddr_i, ADDR_DUTY_BASE + 8'(4 * g));
    end
  endgenerate

  assign tb_en  = control[CTL_EN_BIT];
  assign immediate_update_enable    = control[CTL_IUE_BIT];
  assign mode   = control[CTL_MOD_LSB +: 2];
  assign ops    = control[CTL_OPS_LSB +: 4];
  assign ckps   = control[CTL_CKPS_LSB +: 2];
  assign center = mode[1];

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_comb begin
    case (ckps)
      2'h0:    pre_max = PRE_DIV1;
      2'h1:    pre_max = PRE_DIV4;
      2'h2:    pre_max = PRE_DIV16;
      default: pre_max = PRE_DIV64;
    endcase
  end

  // Compare edges sit at the first cycle of a count step; the half tick is its middle
  assign tick         = tb_en && (pre_cnt == pre_max) && (period != PER_RESET);
  assign step_start   = tb_en && (pre_cnt == 6'h00) && (period != PER_RESET);
  assign half_cnt     = pre_max - (pre_max >> 1);
  assign half_tick    = tb_en && (pre_cnt == half_cnt) && (period != PER_RESET);
  assign period_start = step_start && at_zero;
  assign match     = (count == period);
  assign at_zero   = (count == '0);

  always_comb begin
    next_pre_cnt = pre_cnt;
    if (wr_ctl || wr_cnt) begin
      next_pre_cnt = '0;
    end else if (tb_en) begin
      next_pre_cnt = (pre_cnt == pre_max) ? 6'h00 : pre_cnt + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Counter, direction and period
  // ----------------------------------------------------------------
  always_comb begin
    next_count      = count;
    next_dir_down   = dir_down;
    next_period     = period;
    next_control    = control;
    raw_event       = 1'b0;
    post_used       = 1'b1;
    duty_load       = !tb_en;
    if (!tb_en && period != PER_RESET) begin
      next_period = period_buf;
    end else if (!tb_en && period == PER_RESET) begin
      next_period = period_buf;
    end
    if (tick) begin
      case (mode)
        MODE_FREE, MODE_SINGLE: begin
          if (match) begin
            next_count   = '0;
            next_period  = period_buf;
            raw_event    = 1'b1;
            duty_load    = 1'b1;
            if (mode == MODE_SINGLE) begin
              post_used                = 1'b0;
              next_control[CTL_EN_BIT] = 1'b0;
            end
          end else begin
            next_count = count + 15'h0001;
          end
          next_dir_down = 1'b0;
        end
        MODE_UPDOWN, MODE_DOUBLE: begin
          // Up then down: one output period is two traversals
          if (!dir_down && match) begin
            next_dir_down = 1'b1;
            next_count    = count - 15'h0001;
            if (mode == MODE_DOUBLE) begin
              raw_event = 1'b1;
              duty_load = 1'b1;
              post_used = 1'b0;
            end
          end else if (dir_down && at_zero) begin
            next_dir_down = 1'b0;
            next_count    = count + 15'h0001;
            next_period   = period_buf;
            raw_event     = 1'b1;
            duty_load     = 1'b1;
            post_used     = (mode == MODE_UPDOWN);
          end else if (dir_down) begin
            next_count = count - 15'h0001;
          end else begin
            next_count = count + 15'h0001;
          end
        end
        default: begin
          next_count = count;
        end
      endcase
    end
    if (wr_cnt) begin
      next_count = pwdata_i[CNT_W-1:0];
    end
    if (wr_ctl) begin
      next_control = pwdata_i[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Postscaler
  // ----------------------------------------------------------------
  always_comb begin
    next_post_cnt = post_cnt;
    next_event_q  = 1'b0;
    if (wr_ctl || wr_cnt) begin
      next_post_cnt = '0;
    end else if (raw_event && !post_used) begin
      next_event_q = 1'b1;
    end else if (raw_event) begin
      if (post_cnt == ops) begin
        next_post_cnt = '0;
        next_event_q  = 1'b1;
      end else begin
        next_post_cnt = post_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Period and duty buffers, APB read
  // ----------------------------------------------------------------
  always_comb begin
    next_period_buf = wr_per ? pwdata_i[CNT_W-1:0] : period_buf;
    for (int i = 0; i < NUM_GEN; i++) begin
      next_duty_buf[i] = wr_duty[i] ? pwdata_i[DUTY_W-1:0] : duty_buf[i];
    end
    next_ready_q = access;
    next_err_q   = 1'b0;
    next_rdata_q = 32'h0000_0000;
    if (access) begin
      if (hit_addr(paddr_i, ADDR_TB_CONTROL)) begin
        next_rdata_q = {16'h0000, control};
      end else if (hit_addr(paddr_i, ADDR_TB_COUNT)) begin
        next_rdata_q = {16'h0000, dir_down, count};
      end else if (hit_addr(paddr_i, ADDR_TB_PERIOD)) begin
        next_rdata_q = {17'h00000, period_buf};
      end else if (hit_addr(paddr_i, ADDR_STATUS)) begin
        next_rdata_q = {17'h00000, period};
      end else if (wr_duty != '0 || (paddr_i >= ADDR_DUTY_BASE && paddr_i < ADDR_STATUS
                   && paddr_i[1:0] == 2'h0)) begin
        next_rdata_q = {16'h0000, duty_buf[paddr_i[3:2] - 2'h3]};
      end else begin
        next_err_q = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      control    <= CTL_RESET;
      count      <= '0;
      dir_down   <= 1'b0;
      period_buf <= PER_RESET;
      period     <= PER_RESET;
      pre_cnt    <= '0;
      post_cnt   <= '0;
      event_q    <= 1'b0;
      ready_q    <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      err_q      <= 1'b0;
      for (int i = 0; i < NUM_GEN; i++) begin
        duty_buf[i] <= DUTY_RESET;
      end
    end else begin
      control    <= next_control;
      count      <= next_count;
      dir_down   <= next_dir_down;
      period_buf <= next_period_buf;
      period     <= next_period;
      pre_cnt    <= next_pre_cnt;
      post_cnt   <= next_post_cnt;
      event_q    <= next_event_q;
      ready_q    <= next_ready_q;
      rdata_q    <= next_rdata_q;
      err_q      <= next_err_q;
      for (int i = 0; i < NUM_GEN; i++) begin
        duty_buf[i] <= next_duty_buf[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Duty comparators
  // ----------------------------------------------------------------
  logic [NUM_GEN-1:0] cmp_active;
  logic [NUM_GEN-1:0] pwm_q;

  generate
    for (g = 0; g < NUM_GEN; g++) begin : g_cmp
      mptd_duty_compare u_cmp (
        .clk_i           (clk_i),
        .reset_i         (reset_i),
        .count_i         (count),
        .period_i        (period),
        .counting_down_i (dir_down),
        .center_i        (center),
        .tick_i          (step_start),
        .half_tick_i     (half_tick),
        .period_start_i  (period_start),
        .buffer_i        (next_duty_buf[g]),
        .load_i          (duty_load || (immediate_update_enable && wr_duty[g])),
        .active_o        (cmp_active[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwm_q <= '0;
    end else begin
      pwm_q <= cmp_active;
    end
  end

  assign pready_o     = ready_q;
  assign prdata_o     = rdata_q;
  assign pslverr_o    = err_q;
  assign tb_event_o   = event_q;
  assign pwm_active_o = pwm_q;
endmodule
`default_nettype wire

//--- verification/mptd_timebase_checker.sv
// Checker: APB handshake, read data framing and reset behaviour of the time base
`timescale 1ns/1ps
`default_nettype none
module mptd_timebase_checker
  import mptd_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  // APB
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic               pready_o,
  input  wire logic [31:0]        prdata_o,
  input  wire logic               pslverr_o,
  // Time base
  input  wire logic               tb_event_o,
  input  wire logic [NUM_GEN-1:0] pwm_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_ready_follows;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  property p_ready_cause;
    $rose(pready_o) |-> $past(psel_i && penable_i);
  endproperty
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  property p_err_with_ready;
    pslverr_o |-> pready_o && psel_i;
  endproperty
  property p_err_data;
    pslverr_o && !pwrite_i |-> prdata_o == 32'h0;
  endproperty
  property p_unmapped;
    psel_i && penable_i && !pready_o && paddr_i > ADDR_STATUS |=> pslverr_o;
  endproperty
  property p_mapped;
    psel_i && penable_i && !pready_o && paddr_i <= ADDR_STATUS && paddr_i[1:0] == 2'h0
      |=> !pslverr_o;
  endproperty
  property p_count_read;
    pready_o && !pwrite_i && paddr_i == ADDR_TB_COUNT |-> prdata_o[31:16] == 16'h0;
  endproperty
  property p_period_read;
    pready_o && !pwrite_i && paddr_i == ADDR_TB_PERIOD |-> prdata_o[31:15] == 17'h0;
  endproperty
  // Only the first cycle after release is checked, a held reset is masked
  property p_reset_quiet;
    $fell(reset_i) |-> !tb_event_o && pwm_active_o == 4'h0 && !pready_o;
  endproperty
  a_ready_follows:  assert property (p_ready_follows) else $error("pready late");
  a_ready_cause:    assert property (p_ready_cause) else $error("pready without access");
  a_ready_pulse:    assert property (p_ready_pulse) else $error("pready held");
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  a_err_data:       assert property (p_err_data) else $error("error read data not zero");
  a_unmapped:       assert property (p_unmapped) else $error("unmapped access accepted");
  a_mapped:         assert property (p_mapped) else $error("mapped access refused");
  a_count_read:     assert property (p_count_read) else $error("count upper bits");
  a_period_read:    assert property (p_period_read) else $error("period upper bits");
  a_reset_quiet:    assert property (p_reset_quiet) else $error("outputs after reset");
  c_event:   cover property (tb_event_o);
  c_error:   cover property (pslverr_o);
  c_pwm_on:  cover property ($rose(pwm_active_o[0]));
endmodule
bind mptd_timebase mptd_timebase_checker u_mptd_timebase_checker (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .prdata_o(prdata_o),
  .pslverr_o(pslverr_o), .tb_event_o(tb_event_o), .pwm_active_o(pwm_active_o));
`default_nettype wire

//--- verification/mptd_timebase_bench.sv
// Testbench: PWM time base against a register and timing model
`timescale 1ns/1ps
`default_nettype none
module mptd_timebase_bench
  import mptd_pkg::*;
;
  logic               clk_i;
  logic               reset_i;
  logic               psel_i;
  logic               penable_i;
  logic               pwrite_i;
  logic [7:0]         paddr_i;
  logic [31:0]        pwdata_i;
  logic               pready_o;
  logic [31:0]        prdata_o;
  logic               pslverr_o;
  logic               tb_event_o;
  logic [NUM_GEN-1:0] pwm_active_o;
  int                 fail_count;
  int                 compares;
  int                 cycles;
  int                 i;
  int                 n;
  int                 p;
  int                 ev;
  logic [1:0]         m;
  logic [3:0]         ops;
  logic [31:0]        r;
  logic [31:0]        r0;
  logic               e;
  logic [31:0]        model_reg [8];

  mptd_timebase u_mptd_timebase (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .tb_event_o(tb_event_o),
    .pwm_active_o(pwm_active_o));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // A hang anywhere ends the run through the same report
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [31:0] reg_mask(input logic [7:0] a);
    case (a)
      ADDR_TB_CONTROL: return 32'h0000C0FF;
      ADDR_TB_COUNT, ADDR_TB_PERIOD: return 32'h00007FFF;
      ADDR_STATUS: return 32'h00000000;
      default: return 32'h0000FFFF;
    endcase
  endfunction
  // Changes follow a rising edge; pready and the answer are taken at that same rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
    model_reg[a[4:2]] = d & reg_mask(a);
    if (!model_reg[0][15]) model_reg[7] = model_reg[2];
  endtask
  task automatic rdc(input logic [7:0] a, input string what);
    apb(1'b0, a, 32'h0, r, e);
    chk(r, model_reg[a[4:2]], what);
  endtask
  task automatic wait_ev(input int lim, output int k);
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (!tb_event_o && k < lim);
  endtask
  task automatic run(input logic [1:0] md, input logic [1:0] ck, input logic [3:0] os,
                     input int per);
    wr(ADDR_TB_CONTROL, 32'h0);
    wr(ADDR_TB_COUNT, 32'h0);
    wr(ADDR_TB_PERIOD, 32'(per));
    wr(ADDR_TB_CONTROL, 32'h8000 | {os, ck, md});
  endtask
  // Duties are written while halted so they load at once
  task automatic duty_run(input logic [1:0] md, input int per, input int win,
                          input int dv [4], input int eh [4]);
    int hi;
    wr(ADDR_TB_CONTROL, 32'h0);
    for (int g = 0; g < 4; g++) wr(ADDR_DUTY_BASE + 8'(4 * g), 32'(dv[g]));
    run(md, 2'h0, 4'h0, per);
    repeat (3) wait_ev(200, n);
    for (int g = 0; g < 4; g++) begin
      hi = 0;
      repeat (win) begin
        @(negedge clk_i);
        hi += int'(pwm_active_o[g] === 1'b1);
      end
      chk(32'(hi), 32'(eh[g]), "active cycles");
    end
    $display("duty test done");
  endtask
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fail_count = 0;
    compares = 0;
    cycles = 0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    model_reg = '{default: 32'h0};
    reset_i = 1'b1;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    void'($urandom(37));
    for (i = 0; i < 8; i++) rdc(8'(4 * i), "reset value");
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk(r, 32'h0, "unmapped data");
    chk(32'(e), 32'h1, "unmapped error");
    wr(ADDR_TB_CONTROL, 32'h00F6);
    wr(ADDR_TB_COUNT, 32'hFFFFFFFF);
    wr(ADDR_TB_PERIOD, $urandom);
    for (i = 0; i < 4; i++) wr(ADDR_DUTY_BASE + 8'(4 * i), $urandom);
    for (i = 0; i < 8; i++) rdc(8'(4 * i), "register readback");
    $display("register test done");
    for (i = 0; i < 3; i++) begin
      m = (i == 0) ? MODE_FREE : (i == 1) ? MODE_UPDOWN : MODE_DOUBLE;
      p = 3 + $urandom_range(7);
      ops = 4'($urandom_range(15));
      run(m, 2'h0, ops, p);
      ev = (i == 0) ? (p + 1) * (ops + 1) : (i == 1) ? 2 * p * (ops + 1) : p;
      wait_ev(2000, n);
      wait_ev(2000, n);
      chk(32'(n), 32'(ev), "event spacing");
    end
    wr(ADDR_TB_CONTROL, 32'h0);
    apb(1'b0, ADDR_TB_COUNT, 32'h0, r0, e);
    repeat (20) @(negedge clk_i);
    apb(1'b0, ADDR_TB_COUNT, 32'h0, r, e);
    chk(r, r0, "count held while disabled");
    run(MODE_FREE, 2'h0, 4'h0, 30);
    wait_ev(100, n);
    wr(ADDR_TB_PERIOD, 32'd9);
    rdc(ADDR_STATUS, "period held until boundary");
    wait_ev(100, n);
    wait_ev(100, n);
    chk(32'(n), 32'd10, "buffered period spacing");
    $display("mode test done");
    for (i = 0; i < 4; i++) begin
      p = 3 + $urandom_range(7);
      run(MODE_FREE, 2'(i), 4'h0, p);
      wait_ev(20000, n);
      wait_ev(20000, n);
      chk(32'(n), 32'((p + 1) * (1 << (2 * i))), "prescaled spacing");
    end
    $display("prescale test done");
    run(MODE_SINGLE, 2'h0, 4'h5, 5);
    wait_ev(200, n);
    chk(32'(tb_event_o), 32'h1, "single shot event");
    wait_ev(100, n);
    chk(32'(n), 32'd100, "single shot quiet");
    model_reg[0] = 32'h0051;
    model_reg[1] = 32'h0;
    rdc(ADDR_TB_CONTROL, "single shot stop");
    rdc(ADDR_TB_COUNT, "single shot clear");
    run(MODE_FREE, 2'h0, 4'h0, 0);
    wait_ev(300, n);
    chk(32'(n), 32'd300, "zero period halt");
    $display("single shot test done");
    duty_run(MODE_FREE, 20, 84, '{0, 14, 65534, 15}, '{0, 28, 84, 28});
    duty_run(MODE_UPDOWN, 20, 160, '{0, 40, 65534, 20}, '{0, 160, 160, 80});
    wr(ADDR_TB_CONTROL, 32'h0);
    wr(ADDR_DUTY_BASE, 32'd300);
    wr(ADDR_TB_PERIOD, 32'd200);
    wr(ADDR_TB_CONTROL, 32'hC000);
    wait_ev(500, n);
    repeat (20) @(negedge clk_i);
    chk(32'(pwm_active_o[0]), 32'h1, "active before update");
    wr(ADDR_DUTY_BASE, 32'h0);
    repeat (8) @(negedge clk_i);
    chk(32'(pwm_active_o[0]), 32'h0, "immediate update");
    $display("immediate update test done");
    print_verdict();
  end
endmodule
`default_nettype wire
